// File: hw/ptw_map.vh
// Constants for the paging translation and table walk unit.
`ifndef PTW_MAP_VH
`define PTW_MAP_VH
// Register byte offsets on the APB bus.
`define PTW_OFS_DIR_BASE   12'h000
`define PTW_OFS_FAULT_LIN  12'h004
`define PTW_OFS_ERR_CODE   12'h008
`define PTW_OFS_SAVED_IP   12'h00C
`define PTW_OFS_STATUS     12'h010
// Table entry flag positions.
`define PTW_BIT_P          0
`define PTW_BIT_RW         1
`define PTW_BIT_US         2
`define PTW_BIT_A          5
`define PTW_BIT_D          6
// Exception vector for a page fault.
`define PTW_VEC_PF         8'h0E
// Reset values.
`define PTW_RST_WORD       32'h0000_0000
`endif

// File: hw/ptw_unit.v
// Paging unit: translation cache, two-level table walk and fault reporting.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "ptw_map.vh"
module ptw_unit (
   // Clock, reset and clock enable.
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_ce,
   // Request from the segmentation logic.
   input  wire        i_req,
   input  wire [31:0] i_lin_addr,
   input  wire        i_write,
   input  wire        i_user,
   input  wire        i_desc_acc,
   input  wire [31:0] i_wdata,
   input  wire [31:0] i_instr_ptr,
   input  wire        i_handler_entry,
   // Task switch reload of the directory base.
   input  wire        i_task_switch,
   input  wire [31:0] i_task_dir_base,
   // Answer to the segmentation logic.
   output reg         o_busy,
   output reg         o_done,
   output reg         o_fault,
   output reg  [7:0]  o_fault_vec,
   output reg  [15:0] o_err_code,
   output reg  [31:0] o_rdata,
   // External memory bus.
   output reg         o_mem_req,
   output reg  [31:0] o_mem_addr,
   output reg         o_mem_we,
   output reg  [31:0] o_mem_wdata,
   output reg         o_mem_lock,
   input  wire        i_mem_ack,
   input  wire [31:0] i_mem_rdata,
   // APB register port.
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output reg         o_pready,
   output reg         o_pslverr
);
   // Walk states.
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_LOOK = 3'd1;
   localparam [2:0] S_PDRD = 3'd2;
   localparam [2:0] S_PDWR = 3'd3;
   localparam [2:0] S_PTRD = 3'd4;
   localparam [2:0] S_PTWR = 3'd5;
   localparam [2:0] S_OPER = 3'd6;

   reg  [2:0]  state;           // Walk state.
   reg  [31:0] la;              // Latched linear address.
   reg         acc_wr;          // Latched write direction.
   reg         acc_usr;         // Latched user mode.
   reg         acc_desc;        // Latched descriptor table access.
   reg  [31:0] acc_wdata;       // Latched operand write data.
   reg  [31:0] acc_ip;          // Latched instruction pointer.
   reg  [31:0] pde;             // Fetched directory entry.
   reg  [31:0] directory_base_reg;
   reg  [31:0] fault_linear_address_reg;
   reg  [31:0] saved_instruction_pointer;
   reg         nested_fault;    // Last fault struck during handler entry.
   reg  [15:0] fault_cnt;       // Faults seen since reset.

   // Translation cache: 8 sets of 4 ways, index {set, way}.
   reg  [19:0] tlb_tag [0:31];
   reg  [19:0] tlb_frm [0:31];
   reg  [31:0] tlb_vld;
   reg  [31:0] tlb_usr;
   reg  [31:0] tlb_rw;
   reg  [31:0] tlb_drt;
   reg  [2:0]  plru [0:7];      // Tree bits per set.

   wire [2:0]  set = la[14:12]; // Set index from low page number bits.

   // Way search inside the selected set.
   reg         hit;
   reg  [1:0]  hit_way;
   reg         free;
   reg  [1:0]  free_way;
   integer     w;
   always @* begin
      hit      = 1'b0;
      hit_way  = 2'd0;
      free     = 1'b0;
      free_way = 2'd0;
      for (w = 3; w >= 0; w = w - 1) begin
         // Upper 20 linear bits against each valid tag.
         if (tlb_vld[{set, w[1:0]}] && tlb_tag[{set, w[1:0]}] == la[31:12]) begin
            hit     = 1'b1;
            hit_way = w[1:0];
         end
         if (!tlb_vld[{set, w[1:0]}]) begin
            free     = 1'b1;
            free_way = w[1:0];
         end
      end
   end

   wire [4:0]  hidx = {set, hit_way};
   // Victim: the hit way on a re-walk, so no tag is held twice; else free, else tree.
   wire [2:0]  tree = plru[set];
   wire [1:0]  plru_way = tree[0] ? {1'b1, tree[2]} : {1'b0, tree[1]};
   wire [1:0]  vict = hit ? hit_way : (free ? free_way : plru_way);

   // Effective user mode: descriptor table accesses count as supervisor.
   wire        eff_usr = acc_usr & ~acc_desc;

   // Rights of the fetched table entry combined with the directory entry.
   wire        pt_u  = pde[`PTW_BIT_US] & i_mem_rdata[`PTW_BIT_US];
   wire        pt_w  = pde[`PTW_BIT_RW] & i_mem_rdata[`PTW_BIT_RW];
   wire        pt_pv = eff_usr & (~pt_u | (acc_wr & ~pt_w));
   // Rights of a cached entry.
   wire        hc_pv = eff_usr & (~tlb_usr[hidx] | (acc_wr & ~tlb_rw[hidx]));

   // APB decode; the access phase is the one that completes.
   wire        apb_acc = i_psel & i_penable & o_pready;
   wire        apb_wr  = apb_acc & i_pwrite;
   wire        dir_wr  = apb_wr & (i_paddr == `PTW_OFS_DIR_BASE);
   // Any directory base load flushes the cache.
   wire        flush   = dir_wr | i_task_switch;

   // Tree update on a touch of a way.
   function [2:0] plru_touch;
      input [2:0] t;
      input [1:0] wy;
      begin
         plru_touch    = t;
         plru_touch[0] = ~wy[1];
         if (wy[1])
            plru_touch[2] = ~wy[0];
         else
            plru_touch[1] = ~wy[0];
      end
   endfunction

   // Start a memory cycle on the external bus.
   task mem_start;
      input [31:0] a;
      input        we;
      input [31:0] d;
      input        lk;
      begin
         o_mem_req   <= 1'b1;
         o_mem_addr  <= a;
         o_mem_we    <= we;
         o_mem_wdata <= d;
         o_mem_lock  <= lk;
      end
   endtask

   // Raise a page fault with the given cause and return to idle.
   task raise_fault;
      input prot;
      begin
         o_done      <= 1'b1;
         o_fault     <= 1'b1;
         o_busy      <= 1'b0;
         o_mem_lock  <= 1'b0;
         // Vector stays 14 even during handler entry.
         o_fault_vec <= `PTW_VEC_PF;
         nested_fault <= i_handler_entry;
         o_err_code  <= {13'h0000, eff_usr, acc_wr, prot};
         fault_linear_address_reg  <= la;
         saved_instruction_pointer <= acc_ip;
         fault_cnt   <= fault_cnt + 16'h0001;
         state       <= S_IDLE;
      end
   endtask

   // Load a cache entry after a successful walk.
   task fill;
      input [31:0] pte;
      input        drt;
      begin
         tlb_tag[{set, vict}] <= la[31:12];
         tlb_frm[{set, vict}] <= pte[31:12];
         tlb_usr[{set, vict}] <= pde[`PTW_BIT_US] & pte[`PTW_BIT_US];
         tlb_rw[{set, vict}]  <= pde[`PTW_BIT_RW] & pte[`PTW_BIT_RW];
         tlb_drt[{set, vict}] <= drt;
         tlb_vld[{set, vict}] <= 1'b1;
         plru[set] <= plru_touch(tree, vict);
      end
   endtask

   // Walk state machine, cache and directory base.
   integer s;
   always @(posedge i_clk) begin
      if (i_rst) begin
         state       <= S_IDLE;
         la          <= `PTW_RST_WORD;
         acc_wr      <= 1'b0;
         acc_usr     <= 1'b0;
         acc_desc    <= 1'b0;
         acc_wdata   <= `PTW_RST_WORD;
         acc_ip      <= `PTW_RST_WORD;
         pde         <= `PTW_RST_WORD;
         directory_base_reg        <= `PTW_RST_WORD;
         fault_linear_address_reg  <= `PTW_RST_WORD;
         saved_instruction_pointer <= `PTW_RST_WORD;
         nested_fault <= 1'b0;
         fault_cnt   <= 16'h0000;
         tlb_vld     <= 32'h0000_0000;
         tlb_usr     <= 32'h0000_0000;
         tlb_rw      <= 32'h0000_0000;
         tlb_drt     <= 32'h0000_0000;
         for (s = 0; s < 8; s = s + 1)
            plru[s] <= 3'b000;
         o_busy      <= 1'b0;
         o_done      <= 1'b0;
         o_fault     <= 1'b0;
         o_fault_vec <= 8'h00;
         o_err_code  <= 16'h0000;
         o_rdata     <= `PTW_RST_WORD;
         o_mem_req   <= 1'b0;
         o_mem_addr  <= `PTW_RST_WORD;
         o_mem_we    <= 1'b0;
         o_mem_wdata <= `PTW_RST_WORD;
         o_mem_lock  <= 1'b0;
      end else if (i_ce) begin
         // Completion is a one-cycle pulse.
         o_done  <= 1'b0;
         o_fault <= 1'b0;
         case (state)
            // Take a request from segmentation.
            S_IDLE: begin
               if (i_req) begin
                  la        <= i_lin_addr;
                  acc_wr    <= i_write;
                  acc_usr   <= i_user;
                  acc_desc  <= i_desc_acc;
                  acc_wdata <= i_wdata;
                  acc_ip    <= i_instr_ptr;
                  o_busy    <= 1'b1;
                  state     <= S_LOOK;
               end
            end
            // Cache lookup.
            S_LOOK: begin
               if (hit && hc_pv) begin
                  raise_fault(1'b1);
               end else if (hit && !(acc_wr && !tlb_drt[hidx])) begin
                  // Frame plus untranslated offset onto the bus.
                  mem_start({tlb_frm[hidx], la[11:0]}, acc_wr, acc_wdata, 1'b0);
                  plru[set] <= plru_touch(tree, hit_way);
                  state     <= S_OPER;
               end else begin
                  // A miss, or a first write to a clean page, walks the tables.
                  mem_start({directory_base_reg[31:12], la[31:22], 2'b00},
                            1'b0, `PTW_RST_WORD, 1'b1);
                  state <= S_PDRD;
               end
            end
            // Directory entry read, locked.
            S_PDRD: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  pde       <= i_mem_rdata;
                  if (!i_mem_rdata[`PTW_BIT_P]) begin
                     raise_fault(1'b0);
                  end else if (!i_mem_rdata[`PTW_BIT_A]) begin
                     // Write back with accessed set in the same locked cycle.
                     mem_start(o_mem_addr, 1'b1,
                               i_mem_rdata | 32'h0000_0020, 1'b1);
                     state <= S_PDWR;
                  end else begin
                     mem_start({i_mem_rdata[31:12], la[21:12], 2'b00},
                               1'b0, `PTW_RST_WORD, 1'b1);
                     state <= S_PTRD;
                  end
               end
            end
            // Directory entry write-back, then the table entry read, still locked.
            S_PDWR: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  mem_start({pde[31:12], la[21:12], 2'b00},
                            1'b0, `PTW_RST_WORD, 1'b1);
                  state <= S_PTRD;
               end
            end
            // Table entry read, locked.
            S_PTRD: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  if (!i_mem_rdata[`PTW_BIT_P]) begin
                     raise_fault(1'b0);
                  end else if (pt_pv) begin
                     // Refused access: no fill, no dirty update.
                     raise_fault(1'b1);
                  end else if (!i_mem_rdata[`PTW_BIT_A] ||
                               (acc_wr && !i_mem_rdata[`PTW_BIT_D])) begin
                     mem_start(o_mem_addr, 1'b1,
                               i_mem_rdata | 32'h0000_0020 |
                               (acc_wr ? 32'h0000_0040 : 32'h0000_0000),
                               1'b1);
                     pde   <= pde;
                     state <= S_PTWR;
                     fill(i_mem_rdata, acc_wr | i_mem_rdata[`PTW_BIT_D]);
                  end else begin
                     fill(i_mem_rdata, i_mem_rdata[`PTW_BIT_D]);
                     mem_start({i_mem_rdata[31:12], la[11:0]}, acc_wr,
                               acc_wdata, 1'b0);
                     o_mem_lock <= 1'b0;
                     state      <= S_OPER;
                  end
               end
            end
            // Table entry write-back, then the operand access.
            S_PTWR: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  mem_start({o_mem_wdata[31:12], la[11:0]}, acc_wr,
                            acc_wdata, 1'b0);
                  state <= S_OPER;
               end
            end
            // Operand access on the translated address.
            S_OPER: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  o_rdata   <= i_mem_rdata;
                  o_done    <= 1'b1;
                  o_busy    <= 1'b0;
                  state     <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
         // Directory base loads; the task record wins over software.
         if (i_task_switch)
            directory_base_reg <= {i_task_dir_base[31:12], 12'h000};
         else if (dir_wr)
            directory_base_reg <= {i_pwdata[31:12], 12'h000};
         // Flush after any fill so a fill in the same cycle does not survive it.
         if (flush)
            tlb_vld <= 32'h0000_0000;
      end
   end

   // APB slave: one wait-free access phase, errors on unmapped offsets.
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_prdata  <= `PTW_RST_WORD;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else if (i_ce) begin
         // Ready rises for the cycle after setup, once per transfer.
         o_pready  <= i_psel & ~i_penable;
         o_pslverr <= 1'b0;
         if (i_psel && !i_penable) begin
            case (i_paddr)
               `PTW_OFS_DIR_BASE:  o_prdata <= directory_base_reg;
               `PTW_OFS_FAULT_LIN: o_prdata <= fault_linear_address_reg;
               `PTW_OFS_ERR_CODE:  o_prdata <= {16'h0000, o_err_code};
               `PTW_OFS_SAVED_IP:  o_prdata <= saved_instruction_pointer;
               `PTW_OFS_STATUS:    o_prdata <= {fault_cnt, 10'h000, nested_fault,
                                                o_busy, 1'b0, state};
               default: begin
                  o_prdata  <= `PTW_RST_WORD;
                  o_pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // ptw_unit

// File: verif/ptw_mem_model.sv
// Behavioural memory that answers the paging unit's external bus.
`timescale 1ns/1ps
module ptw_mem_model (
   // Clock, reset and pace.
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_slow,
   // Bus from the unit.
   input  wire logic        i_req,
   input  wire logic [31:0] i_addr,
   input  wire logic        i_we,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_lock,
   // Answer to the unit.
   output logic             o_ack,
   output logic [31:0]      o_rdata
);
   logic [31:0] mem [int unsigned];  // Sparse word store by byte address.
   logic [31:0] last;                // Last word returned.
   int          wait_n;              // Cycles waited on this request.
   int          n_lock;              // Locked cycles served, cleared by the bench.
   // One pulse of ack per request; data is scrambled outside the ack cycle.
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~last;
      if (i_rst) begin
         wait_n <= 0;
         last <= 32'h0000_0000;
      end else if (i_req && !o_ack) begin
         if (wait_n >= (i_slow ? 4 : 0)) begin
            wait_n <= 0;
            o_ack <= 1'b1;
            if (i_lock) n_lock = n_lock + 1;
            if (i_we) mem[i_addr] = i_wdata;
            else begin
               last <= mem.exists(i_addr) ? mem[i_addr] : 32'h0000_0000;
               o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 32'h0000_0000;
            end
         end else wait_n <= wait_n + 1;
      end
   end
endmodule // ptw_mem_model

// File: verif/ptw_unit_assertions.sv
// Concurrent checks on the paging unit's ports.
`timescale 1ns/1ps
`include "ptw_map.vh"
module ptw_unit_assertions (
   // Clock, reset and requests.
   input wire        i_clk,
   input wire        i_rst,
   input wire        i_ce,
   input wire        i_req,
   input wire [31:0] i_lin_addr,
   input wire        i_write,
   input wire        i_user,
   input wire        i_desc_acc,
   input wire        i_task_switch,
   input wire [31:0] i_task_dir_base,
   // Answers and memory bus.
   input wire        o_busy,
   input wire        o_done,
   input wire        o_fault,
   input wire [7:0]  o_fault_vec,
   input wire [15:0] o_err_code,
   input wire        o_mem_req,
   input wire [31:0] o_mem_addr,
   input wire        o_mem_we,
   input wire [31:0] o_mem_wdata,
   input wire        o_mem_lock,
   input wire        i_mem_ack,
   // Register bus.
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire        o_pready
);
   logic [31:0] c_lin;  // Linear address of the request in flight.
   logic        c_we;   // Its write flag.
   logic        c_usr;  // Mode bit that a fault on it must report.
   logic [31:0] dbase;  // Directory base as software and task switches set it.
   wire take = i_ce && i_req && !o_busy && !i_rst;  // Request accepted.
   // Follow the request and the directory base from the port traffic.
   always @(posedge i_clk) begin
      if (take) begin
         c_lin <= i_lin_addr;
         c_we <= i_write;
         c_usr <= i_user && !i_desc_acc;
      end
      if (i_rst) dbase <= 32'h0000_0000;
      else if (i_ce && i_task_switch) dbase <= i_task_dir_base & 32'hFFFF_F000;
      else if (i_ce && i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h000)
         dbase <= i_pwdata & 32'hFFFF_F000;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_FAULT_VEC: assert property (o_fault |-> o_done && o_fault_vec == `PTW_VEC_PF)
      else $error("fault without done or with a wrong vector");
   AST_ERR_HIGH: assert property (o_fault |-> o_err_code[15:3] == 13'h0000)
      else $error("error code upper bits not zero");
   AST_ERR_MODE: assert property (o_fault |-> o_err_code[2] == c_usr)
      else $error("error code mode bit wrong");
   AST_ERR_DIR: assert property (o_fault |-> o_err_code[1] == c_we)
      else $error("error code direction bit wrong");
   AST_DONE_BOUND: assert property (take |-> ##[2:300] o_done)
      else $error("request not completed in time");
   AST_BUS_HOLD: assert property (o_mem_req && !i_mem_ack |=>
      o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we) && $stable(o_mem_wdata))
      else $error("memory request changed before ack");
   AST_DIR_FIRST: assert property ($rose(o_mem_lock) && o_mem_req && !o_mem_we
      |-> o_mem_addr == {dbase[31:12], c_lin[31:22], 2'b00})
      else $error("walk did not start at the directory entry");
   AST_OPER_OFS: assert property (o_mem_req && !o_mem_lock
      |-> o_mem_addr[11:0] == c_lin[11:0])
      else $error("operand offset not taken from the linear address");
   AST_BUSY_SPAN: assert property (take |=> o_busy ##[1:300] (o_done && !o_busy))
      else $error("busy flag does not span the request");
   AST_ACC_SET: assert property (o_mem_req && o_mem_we && o_mem_lock |-> o_mem_wdata[5])
      else $error("locked entry write without accessed flag");
   COV_FAULT: cover property (o_fault);
   COV_OK: cover property (o_done && !o_fault);
   COV_RMW: cover property (o_mem_req && o_mem_we && o_mem_lock);
endmodule // ptw_unit_assertions
bind ptw_unit ptw_unit_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
   .i_req(i_req), .i_lin_addr(i_lin_addr), .i_write(i_write), .i_user(i_user),
   .i_desc_acc(i_desc_acc), .i_task_switch(i_task_switch), .i_task_dir_base(i_task_dir_base),
   .o_busy(o_busy), .o_done(o_done), .o_fault(o_fault), .o_fault_vec(o_fault_vec),
   .o_err_code(o_err_code), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
   .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_mem_lock(o_mem_lock),
   .i_mem_ack(i_mem_ack), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready));

// File: verif/paging_tlb_walk_unit_tb_top.sv
// Self-checking bench for the paging unit against a memory model.
`timescale 1ns/1ps
module paging_tlb_walk_unit_tb_top;
   logic        i_clk, i_rst, i_ce, i_req, i_write, i_user, i_desc_acc, slow;
   logic        i_handler_entry, i_task_switch, i_psel, i_penable, i_pwrite;
   logic        o_busy, o_done, o_fault, o_mem_req, o_mem_we, o_mem_lock, i_mem_ack;
   logic        o_pready, o_pslverr, perr, flt;
   logic [7:0]  o_fault_vec;
   logic [11:0] i_paddr;
   logic [15:0] o_err_code, ec;
   logic [31:0] i_lin_addr, i_wdata, i_instr_ptr, i_task_dir_base, i_pwdata;
   logic [31:0] o_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata, o_prdata, rd, prd;
   int          fail_count, n_checks, cyc;
   ptw_unit uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req),
      .i_lin_addr(i_lin_addr), .i_write(i_write), .i_user(i_user), .i_desc_acc(i_desc_acc),
      .i_wdata(i_wdata), .i_instr_ptr(i_instr_ptr), .i_handler_entry(i_handler_entry),
      .i_task_switch(i_task_switch), .i_task_dir_base(i_task_dir_base), .o_busy(o_busy),
      .o_done(o_done), .o_fault(o_fault), .o_fault_vec(o_fault_vec), .o_err_code(o_err_code),
      .o_rdata(o_rdata), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .o_mem_we(o_mem_we),
      .o_mem_wdata(o_mem_wdata), .o_mem_lock(o_mem_lock), .i_mem_ack(i_mem_ack),
      .i_mem_rdata(i_mem_rdata), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr));
   ptw_mem_model mm (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_req(o_mem_req),
      .i_addr(o_mem_addr), .i_we(o_mem_we), .i_wdata(o_mem_wdata), .i_lock(o_mem_lock),
      .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
   // Clock of 4 ns period.
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // A hang counts as a mismatch and ends the run.
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         test_done();
      end
   end
   // Compare one value and report a mismatch.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks = n_checks + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Wait for pready (sel high) or done (sel low), bounded.
   task automatic wt(input bit sel);
      int k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (((sel ? o_pready : o_done) !== 1'b1) && k < 400);
      if ((sel ? o_pready : o_done) !== 1'b1) begin
         fail_count = fail_count + 1;
         $display("ERROR %s expected 1 seen 0", sel ? "pready" : "done");
         test_done();
      end
   endtask
   // One APB transfer; read data and error are taken at the pready edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
      @(posedge i_clk);
      i_penable <= 1'b1;
      wt(1'b1);
      prd = o_prdata;
      perr = o_pslverr;
      {i_psel, i_penable} <= 2'b00;
   endtask
   // One access; wud is write, user, descriptor.
   task automatic acc(input logic [31:0] la, input logic [2:0] wud, input logic [31:0] wd);
      mm.n_lock = 0;
      @(posedge i_clk);
      {i_lin_addr, i_write, i_user, i_desc_acc, i_wdata, i_instr_ptr, i_req} <=
         {la, wud, wd, ~la, 1'b1};
      @(posedge i_clk);
      i_req <= 1'b0;
      wt(1'b0);
      flt = o_fault;
      ec = o_err_code;
      rd = o_rdata;
   endtask
   // Expect a fault with the given cause bits.
   task automatic fchk(input logic [2:0] c);
      chk("fault", 32'h0000_0001, {31'h0, flt});
      chk("err", {29'h0, c}, {16'h0, ec});
      chk("vec", 32'h0000_000E, {24'h0, o_fault_vec});
   endtask
   // Print counts and the verdict, then stop.
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence.
   initial begin
      {i_rst, i_ce, i_req, i_write, i_user, i_desc_acc, i_handler_entry} = 7'h60;
      {i_task_switch, i_psel, i_penable, i_pwrite, slow, i_paddr} = 17'h0_0000;
      {i_lin_addr, i_wdata, i_instr_ptr, i_task_dir_base, i_pwdata} = '0;
      mm.mem[32'h0001_0004] = 32'h0002_0007;
      mm.mem[32'h0003_0004] = 32'h0002_0007;
      mm.mem[32'h0002_000C] = 32'h0005_0007;
      mm.mem[32'h0002_0010] = 32'h0006_0006;
      mm.mem[32'h0002_0014] = 32'h0007_0005;
      mm.mem[32'h0005_0010] = 32'h1234_5678;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      apb(1'b1, 12'h000, 32'h0001_0ABC);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("dir_base", 32'h0001_0000, prd);
      acc(32'h0040_3010, 3'b010, 32'h0000_0000);
      chk("rdata", 32'h1234_5678, rd);
      chk("walked", 32'h0000_0001, {31'h0, mm.n_lock != 0});
      chk("pde", 32'h0002_0027, mm.mem[32'h0001_0004]);
      chk("pte", 32'h0005_0027, mm.mem[32'h0002_000C]);
      slow <= 1'b1;
      acc(32'h0040_3010, 3'b010, 32'h0000_0000);
      chk("hit", 32'h0000_0000, {31'h0, mm.n_lock != 0});
      chk("rdata", 32'h1234_5678, rd);
      acc(32'h0040_3020, 3'b110, 32'hA5A5_0001);
      chk("wdata", 32'hA5A5_0001, mm.mem[32'h0005_0020]);
      chk("dirty", 32'h0005_0067, mm.mem[32'h0002_000C]);
      acc(32'h0040_3024, 3'b110, 32'h0000_0002);
      chk("dirty_hit", 32'h0000_0000, {31'h0, mm.n_lock != 0});
      chk("wdata2", 32'h0000_0002, mm.mem[32'h0005_0024]);
      apb(1'b1, 12'h000, 32'h0001_0000);
      acc(32'h0040_3010, 3'b010, 32'h0000_0000);
      chk("flushed", 32'h0000_0001, {31'h0, mm.n_lock != 0});
      acc(32'h0040_4008, 3'b010, 32'h0000_0000);
      fchk(3'b100);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("fault_lin", 32'h0040_4008, prd);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("saved_ip", ~32'h0040_4008, prd);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("err_reg", 32'h0000_0004, {16'h0, prd[15:0]});
      acc(32'h0080_0000, 3'b100, 32'h0000_0000);
      fchk(3'b010);
      acc(32'h0040_5000, 3'b110, 32'h0000_5A5A);
      fchk(3'b111);
      chk("no_dirty", 32'h0000_0000, mm.mem[32'h0002_0014] & 32'h0000_0040);
      acc(32'h0040_5000, 3'b100, 32'h0000_5A5A);
      chk("sup_ok", 32'h0000_0000, {31'h0, flt});
      chk("pte_rmw", 32'h0007_0065, mm.mem[32'h0002_0014]);
      i_handler_entry <= 1'b1;
      acc(32'h0040_4008, 3'b011, 32'h0000_0000);
      fchk(3'b000);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("nested", 32'h0000_0020, prd & 32'h0000_0020);
      {i_handler_entry, i_task_switch, i_task_dir_base} <= {2'b01, 32'h0003_0000};
      @(posedge i_clk);
      i_task_switch <= 1'b0;
      acc(32'h0040_3010, 3'b010, 32'h0000_0000);
      chk("ts_walk", 32'h0000_0001, {31'h0, mm.n_lock != 0});
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("ts_base", 32'h0003_0000, prd);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk("unmapped", 32'h0000_0001, {31'h0, perr});
      test_done();
   end
endmodule // paging_tlb_walk_unit_tb_top
